/* hdl/arw_pkg.sv */
// Shared constants for the converter result back end.
// Assumes a 250 MHz system clock and a Wishbone slave register map.
package arw_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ARW_OFF_CONTROL0  = 8'h00;
    localparam logic [7:0] ARW_OFF_ACC_CFG   = 8'h04;
    localparam logic [7:0] ARW_OFF_RES_HIGH  = 8'h08;
    localparam logic [7:0] ARW_OFF_RES_LOW   = 8'h0c;
    localparam logic [7:0] ARW_OFF_GT_HIGH   = 8'h10;
    localparam logic [7:0] ARW_OFF_GT_LOW    = 8'h14;
    localparam logic [7:0] ARW_OFF_LT_HIGH   = 8'h18;
    localparam logic [7:0] ARW_OFF_LT_LOW    = 8'h1c;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int ARW_BIT_POWER_ON  = 7;
    localparam int ARW_BIT_BURST_ON  = 6;
    localparam int ARW_BIT_DONE_FLAG = 5;
    localparam int ARW_BIT_BUSY      = 4;
    localparam int ARW_BIT_WIN_FLAG  = 3;
    localparam int ARW_BIT_TWELVE    = 7;
    localparam int ARW_POS_JUSTIFY   = 3;
    localparam int ARW_POS_REPEAT    = 0;

    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [7:0]  ARW_RST_CONTROL0 = 8'h00;
    localparam logic [7:0]  ARW_RST_ACC_CFG  = 8'h00;
    localparam logic [15:0] ARW_RST_GT       = 16'hffff;
    localparam logic [15:0] ARW_RST_LT       = 16'h0000;
    localparam logic [2:0]  ARW_JST_RIGHT    = 3'h0;
    localparam logic [2:0]  ARW_JST_LEFT     = 3'h4;
    localparam logic [2:0]  ARW_RPT_MAX_SEL  = 3'h5;
    localparam logic [6:0]  ARW_RPT_BASE     = 7'h04;
    localparam logic [6:0]  ARW_TWELVE_MIN   = 7'h04;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int ARW_CLK_MHZ       = 250;
    localparam int ARW_PWRUP_TIME_NS = 1000;
    localparam int ARW_PWRUP_CYCLES  = (ARW_PWRUP_TIME_NS * ARW_CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {ARW_ST_IDLE, ARW_ST_PWRUP, ARW_ST_CONV} arw_state_e;

endpackage

/* hdl/arw_accum.sv */
// 16-bit accumulator summing raw 10-bit codes of one burst.
// Assumes add and clear come from logic on the same clock.
`timescale 1ns/1ps
module arw_accum (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        clear_i,
    input  wire logic        add_i,
    input  wire logic [9:0]  code_i,
    output logic      [15:0] sum_o
);
    logic [15:0] sum_ff;

    // ************************************************************
    // Accumulation
    // ************************************************************
    // 16-bit accumulator
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sum_ff <= 16'h0000;
        end else if (clear_i) begin
            sum_ff <= 16'h0000;
        end else if (add_i) begin
            sum_ff <= sum_ff + {6'h00, code_i};
        end
    end

    assign sum_o = sum_ff;

    chk_accum_clear : assert property (@(posedge clock_i) disable iff (!rstn_i)
        clear_i |=> sum_ff == 16'h0000) else $error("accumulator not cleared");
endmodule

/* hdl/arw_window.sv */
// Window comparator on the formatted 16-bit result word.
// Assumes the result and both limits are held steady in flip-flops.
`timescale 1ns/1ps
module arw_window (
    input  wire logic [15:0] result_i,
    input  wire logic [15:0] gt_limit_i,
    input  wire logic [15:0] lt_limit_i,
    output logic             match_o
);
    logic inside_mode;

    // ************************************************************
    // Compare
    // ************************************************************
    // Mode from limits
    assign inside_mode = gt_limit_i < lt_limit_i;

    always_comb begin
        if (inside_mode) begin
            match_o = (result_i > gt_limit_i) && (result_i < lt_limit_i);
        end else begin
            match_o = (result_i > gt_limit_i) || (result_i < lt_limit_i);
        end
    end
endmodule

/* hdl/arw_adc_backend.sv */
// Converter back end: burst sequencing, accumulation, formatting, window.
// Assumes a SAR core on the same clock and a classic Wishbone master.
`timescale 1ns/1ps

// How it works
// - Result bytes update once per burst, after its last conversion
// - Justify 000 right, 100 left
// - Single 10-bit code, full-scale 03ff/ffc0
// - Unused result bits read zero
// - Burst sum shown after last conversion
// - Repeat select 4 to 64 samples
// - Accumulation only with burst operation on
// - 16-bit accumulator, shift right 1-3
// - Power-up once per burst start
// - Window compares result against two limits
// - Window match sets polled/interrupt flag
// - Limit order picks inside or outside
// - Inside: strictly between both limits
// - Done flag per conversion or per burst
// - 12-bit burst sums four conversions unless repeat select sets more
module arw_adc_backend
    import arw_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        conv_trigger_i,
    input  wire logic        core_done_i,
    input  wire logic [9:0]  core_code_i,
    output logic             core_power_o,
    output logic             core_start_o,
    output logic             core_twelve_bit_o,
    output logic             conversion_done_flag_o,
    output logic             window_compare_flag_o
);
    import arw_pkg::*;

    logic [7:0]  control0_ff;
    logic [7:0]  acc_cfg_ff;
    logic [15:0] result_ff;
    logic [15:0] gt_limit_ff;
    logic [15:0] lt_limit_ff;
    logic        done_flag_ff;
    logic        win_flag_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    arw_state_e  state_ff;
    logic [8:0]  pwr_cnt_ff;
    logic [6:0]  conv_cnt_ff;
    logic [6:0]  target_ff;
    logic        start_ff;
    logic        upd_ff;
    logic        eval_ff;
    logic        burst_on;
    logic        power_on;
    logic        twelve_bit;
    logic [2:0]  justify_sel;
    logic [2:0]  repeat_sel;
    logic        wr_en;
    logic        sw_start;
    logic        trigger;
    logic        last_done;
    logic        match;
    logic [15:0] sum;
    logic [15:0] nxt_result;
    logic [6:0]  nxt_target;

    assign burst_on    = control0_ff[ARW_BIT_BURST_ON];
    assign power_on    = control0_ff[ARW_BIT_POWER_ON];
    assign twelve_bit  = acc_cfg_ff[ARW_BIT_TWELVE];
    assign justify_sel = acc_cfg_ff[ARW_POS_JUSTIFY +: 3];
    assign repeat_sel  = acc_cfg_ff[ARW_POS_REPEAT +: 3];

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    // One wait state; writes land on the edge that sees ack high
    assign wr_en = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0];
    assign sw_start = wr_en && (wb_adr_i == ARW_OFF_CONTROL0) && wb_dat_i[ARW_BIT_BUSY];

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
            unique case (wb_adr_i)
                ARW_OFF_CONTROL0: rdata_ff <= {24'h000000, power_on, burst_on,
                                               done_flag_ff, state_ff != ARW_ST_IDLE,
                                               win_flag_ff, 3'h0};
                ARW_OFF_ACC_CFG:  rdata_ff <= {24'h000000, acc_cfg_ff};
                ARW_OFF_RES_HIGH: rdata_ff <= {24'h000000, result_ff[15:8]};
                ARW_OFF_RES_LOW:  rdata_ff <= {24'h000000, result_ff[7:0]};
                ARW_OFF_GT_HIGH:  rdata_ff <= {24'h000000, gt_limit_ff[15:8]};
                ARW_OFF_GT_LOW:   rdata_ff <= {24'h000000, gt_limit_ff[7:0]};
                ARW_OFF_LT_HIGH:  rdata_ff <= {24'h000000, lt_limit_ff[15:8]};
                ARW_OFF_LT_LOW:   rdata_ff <= {24'h000000, lt_limit_ff[7:0]};
                default:          rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            control0_ff <= ARW_RST_CONTROL0;
            acc_cfg_ff  <= ARW_RST_ACC_CFG;
            gt_limit_ff <= ARW_RST_GT;
            lt_limit_ff <= ARW_RST_LT;
        end else if (wr_en) begin
            unique case (wb_adr_i)
                ARW_OFF_CONTROL0: control0_ff <= wb_dat_i[7:0];
                ARW_OFF_ACC_CFG:  acc_cfg_ff  <= wb_dat_i[7:0];
                ARW_OFF_GT_HIGH:  gt_limit_ff[15:8] <= wb_dat_i[7:0];
                ARW_OFF_GT_LOW:   gt_limit_ff[7:0]  <= wb_dat_i[7:0];
                ARW_OFF_LT_HIGH:  lt_limit_ff[15:8] <= wb_dat_i[7:0];
                ARW_OFF_LT_LOW:   lt_limit_ff[7:0]  <= wb_dat_i[7:0];
                default:          control0_ff <= control0_ff;
            endcase
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    // Triggers during a busy burst are dropped, as the core cannot queue them
    assign trigger   = (conv_trigger_i || sw_start) && (power_on || burst_on);
    assign last_done = (state_ff == ARW_ST_CONV) && core_done_i && (conv_cnt_ff == target_ff - 7'h01);

    always_comb begin
        if (!burst_on) begin
            nxt_target = 7'h01;
        end else if (repeat_sel != 3'h0) begin
            nxt_target = ARW_RPT_BASE << ((repeat_sel > ARW_RPT_MAX_SEL ?
                          ARW_RPT_MAX_SEL : repeat_sel) - 3'h1);
        end else if (twelve_bit) begin
            nxt_target = ARW_TWELVE_MIN;
        end else begin
            nxt_target = 7'h01;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff    <= ARW_ST_IDLE;
            pwr_cnt_ff  <= 9'h000;
            conv_cnt_ff <= 7'h00;
            target_ff   <= 7'h01;
            start_ff    <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            unique case (state_ff)
                ARW_ST_IDLE: begin
                    conv_cnt_ff <= 7'h00;
                    if (trigger) begin
                        target_ff <= nxt_target;
                        if (burst_on && !power_on) begin
                            state_ff   <= ARW_ST_PWRUP;
                            pwr_cnt_ff <= 9'(ARW_PWRUP_CYCLES - 1);
                        end else begin
                            state_ff <= ARW_ST_CONV;
                            start_ff <= 1'b1;
                        end
                    end
                end
                ARW_ST_PWRUP: begin
                    if (pwr_cnt_ff == 9'h000) begin
                        state_ff <= ARW_ST_CONV;
                        start_ff <= 1'b1;
                    end else begin
                        pwr_cnt_ff <= pwr_cnt_ff - 9'h001;
                    end
                end
                ARW_ST_CONV: begin
                    if (core_done_i) begin
                        conv_cnt_ff <= conv_cnt_ff + 7'h01;
                        if (last_done) begin
                            state_ff <= ARW_ST_IDLE;
                        end else begin
                            start_ff <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    assign core_start_o      = start_ff;
    assign core_power_o      = power_on || (state_ff != ARW_ST_IDLE);
    assign core_twelve_bit_o = twelve_bit;

    arw_accum u_accum (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .clear_i (start_ff && conv_cnt_ff == 7'h00),
        .add_i   ((state_ff == ARW_ST_CONV) && core_done_i),
        .code_i  (core_code_i),
        .sum_o   (sum)
    );

    // ************************************************************
    // Result formatting
    // ************************************************************
    always_comb begin
        if (justify_sel[2]) begin
            nxt_result = {sum[9:0], 6'h00};
        end else begin
            nxt_result = sum >> justify_sel[1:0];
        end
    end

    // Result is taken the cycle after the last add so the sum is complete
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            upd_ff    <= 1'b0;
            eval_ff   <= 1'b0;
            result_ff <= 16'h0000;
        end else begin
            upd_ff  <= last_done;
            eval_ff <= upd_ff;
            if (upd_ff) begin
                result_ff <= nxt_result;
            end
        end
    end

    arw_window u_window (
        .result_i   (result_ff),
        .gt_limit_i (gt_limit_ff),
        .lt_limit_i (lt_limit_ff),
        .match_o    (match)
    );

    // ************************************************************
    // Status flags
    // ************************************************************
    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_flag_ff <= 1'b0;
            win_flag_ff  <= 1'b0;
        end else begin
            if (upd_ff) begin
                done_flag_ff <= 1'b1;
            end else if (wr_en && wb_adr_i == ARW_OFF_CONTROL0) begin
                done_flag_ff <= wb_dat_i[ARW_BIT_DONE_FLAG];
            end
            if (eval_ff && match) begin
                win_flag_ff <= 1'b1;
            end else if (wr_en && wb_adr_i == ARW_OFF_CONTROL0) begin
                win_flag_ff <= wb_dat_i[ARW_BIT_WIN_FLAG];
            end
        end
    end

    assign conversion_done_flag_o = done_flag_ff;
    assign window_compare_flag_o  = win_flag_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    chk_result_only_end : assert property ($changed(result_ff) |-> $past(upd_ff))
        else $error("result changed outside an update");
    chk_done_after_upd : assert property (upd_ff |=> done_flag_ff)
        else $error("done flag not set after update");
    chk_win_sticky : assert property (win_flag_ff && !wr_en |=> win_flag_ff)
        else $error("window flag dropped without clear");
    chk_win_set_match : assert property (eval_ff && match |=> win_flag_ff)
        else $error("window match did not set flag");
    chk_left_zero_low : assert property (upd_ff && justify_sel[2]
        |=> result_ff[5:0] == 6'h00)
        else $error("left-justified low bits not zero");
    chk_right_single : assert property (upd_ff && justify_sel == ARW_JST_RIGHT
        && target_ff == 7'h01 |=> result_ff[15:10] == 6'h00)
        else $error("right-justified single code too wide");
    chk_pwrup_once : assert property (state_ff == ARW_ST_CONV && core_done_i
        && !last_done |=> state_ff == ARW_ST_CONV && core_start_o)
        else $error("power-up inside a burst");
    chk_single_no_burst : assert property (state_ff == ARW_ST_IDLE && trigger
        && !burst_on |=> target_ff == 7'h01)
        else $error("accumulation without burst");
    chk_pwrup_length : assert property ($rose(state_ff == ARW_ST_PWRUP)
        |-> ##250 state_ff == ARW_ST_CONV)
        else $error("power-up length wrong");
    chk_ack_one : assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over two cycles");

    cov_burst_64 : cover property (upd_ff && target_ff == 7'h40);
    cov_window_set : cover property ($rose(win_flag_ff));
    cov_pwrup : cover property (state_ff == ARW_ST_PWRUP ##1 state_ff == ARW_ST_CONV);
endmodule

/* dv/arw_sar_core_model.sv */
// Behavioural converter core on the far side of the result back end.
// Assumes start pulses on the system clock and a same-clock done pulse.
`timescale 1ns/1ps
module arw_sar_core_model (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       start_i,
    input  wire logic       slow_i,
    output logic            done_o,
    output logic      [9:0] code_o
);
    // ************************************************************
    // Conversion timing
    // ************************************************************
    int         cnt;
    logic [9:0] last_code;
    logic [9:0] nxt_code;

    // Code is only valid with done; otherwise the inverse of the last one
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt       <= 0;
            done_o    <= 1'b0;
            code_o    <= 10'h000;
            last_code <= 10'h3ff;
        end else begin
            done_o <= 1'b0;
            code_o <= ~last_code;
            if (start_i) begin
                cnt <= slow_i ? 9 : 2;
            end else if (cnt == 1) begin
                // Full scale now and then so the top code 3ff is seen
                nxt_code = ($urandom % 4 == 0) ? 10'h3ff : 10'($urandom);
                cnt       <= 0;
                done_o    <= 1'b1;
                code_o    <= nxt_code;
                last_code <= nxt_code;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the converter result back end.
// Assumes the design acks a Wishbone request one cycle after it starts.
`timescale 1ns/1ps
module tb_top;
    import arw_pkg::*;
    logic        clock_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, conv_trigger_i, slow;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        wb_ack_o, core_done_i, core_power_o, core_start_o, core_twelve_bit_o;
    logic        done_flag, win_flag, pwr_q, win_exp;
    logic [9:0]  core_code_i;
    logic [15:0] res, gt, lt, expv;
    int          fail_count, n_compared, n_done, n_pwr, sum;
    logic [7:0]  rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

    arw_adc_backend u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .conv_trigger_i(conv_trigger_i), .core_done_i(core_done_i), .core_code_i(core_code_i),
        .core_power_o(core_power_o), .core_start_o(core_start_o),
        .core_twelve_bit_o(core_twelve_bit_o), .conversion_done_flag_o(done_flag),
        .window_compare_flag_o(win_flag));
    arw_sar_core_model u_core (.clock_i(clock_i), .rstn_i(rstn_i), .start_i(core_start_o),
        .slow_i(slow), .done_o(core_done_i), .code_o(core_code_i));

    // ************************************************************
    // Clock, monitor and watchdog
    // ************************************************************
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        pwr_q <= core_power_o;
        if (core_done_i === 1'b1) begin
            sum += core_code_i;
            n_done++;
        end
        if (core_power_o === 1'b1 && pwr_q !== 1'b1) n_pwr++;
    end
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end

    // ************************************************************
    // Reference model and bus tasks
    // ************************************************************
    function automatic logic [15:0] fmt(input logic [15:0] s, input logic [2:0] j);
        return j[2] ? {s[9:0], 6'h00} : (s >> j[1:0]);
    endfunction
    function automatic logic mtch(input logic [15:0] r);
        return (gt < lt) ? (r > gt && r < lt) : (r > gt || r < lt);
    endfunction
    function automatic int nconv(input logic bu, input logic [7:0] c);
        if (!bu) return 1;
        if (c[2:0] == 3'h0) return c[7] ? 4 : 1;
        return 4 << ((c[2:0] > 3'h5 ? 5 : int'(c[2:0])) - 1);
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clock_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (t >= 50) chk("bus ack", 16'h1, 16'h0);
    endtask
    task automatic run(input logic pw, input logic bu, input logic [7:0] cfg,
                       input logic sw = 1'b0);
        int t;
        t  = 0;
        gt = 16'($urandom);
        lt = 16'($urandom);
        wb(1'b1, ARW_OFF_GT_HIGH, gt[15:8]);
        wb(1'b1, ARW_OFF_GT_LOW, gt[7:0]);
        wb(1'b1, ARW_OFF_LT_HIGH, lt[15:8]);
        wb(1'b1, ARW_OFF_LT_LOW, lt[7:0]);
        wb(1'b1, ARW_OFF_ACC_CFG, cfg);
        // Window flag written back as held; done flag cleared
        wb(1'b1, ARW_OFF_CONTROL0, {pw, bu, 2'b00, win_exp, 3'b000});
        sum    = 0;
        n_done = 0;
        n_pwr  = 0;
        @(posedge clock_i);
        slow <= 1'($urandom);
        if (sw) begin
            // Software start through the busy bit instead of the trigger pin
            wb(1'b1, ARW_OFF_CONTROL0, {pw, bu, 2'b01, win_exp, 3'b000});
        end else begin
            conv_trigger_i <= 1'b1;
            @(posedge clock_i);
            conv_trigger_i <= 1'b0;
        end
        while (done_flag !== 1'b1 && t < 5000) begin
            @(posedge clock_i);
            t++;
        end
        repeat (3) @(posedge clock_i);
        expv    = fmt(16'(sum), cfg[5:3]);
        win_exp = win_exp | mtch(expv);
        chk("conversion count", 16'(nconv(bu, cfg)), 16'(n_done));
        chk("twelve-bit pin", {15'h0, cfg[7]}, {15'h0, core_twelve_bit_o});
        chk("done flag pin", 16'h1, {15'h0, done_flag});
        chk("window flag pin", {15'h0, win_exp}, {15'h0, win_flag});
        if (bu && !pw) chk("power-up count", 16'h1, 16'(n_pwr));
        wb(1'b0, ARW_OFF_RES_HIGH, 8'h00);
        res[15:8] = rd[7:0];
        wb(1'b0, ARW_OFF_RES_LOW, 8'h00);
        res[7:0] = rd[7:0];
        chk("result word", expv, res);
        wb(1'b0, ARW_OFF_CONTROL0, 8'h00);
        chk("status bits", {11'h0, pw, bu, 1'b1, 1'b0, win_exp}, {11'h0, rd[7:3]});
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, conv_trigger_i, slow} = 6'h00;
        {wb_adr_i, wb_dat_i, fail_count, n_compared, n_done, n_pwr, sum} = '0;
        wb_sel_i = 4'hf;
        win_exp  = 1'b0;
        void'($urandom(32'h71c2f966));
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        wb(1'b1, 8'h20, 8'h5a);
        for (int i = 0; i < 9; i++) begin
            wb(1'b0, 8'(i * 4), 8'h00);
            chk("reset value", {8'h00, rst_val[i]}, {8'h00, rd[7:0]});
        end
        // A write without the low byte lane must leave the limit alone
        wb_sel_i <= 4'he;
        wb(1'b1, ARW_OFF_GT_HIGH, 8'h12);
        wb_sel_i <= 4'hf;
        wb(1'b0, ARW_OFF_GT_HIGH, 8'h00);
        chk("masked write", {8'h00, ARW_RST_GT[15:8]}, {8'h00, rd[7:0]});
        for (int j = 0; j < 8; j++) run(1'b1, 1'b0, 8'(j << 3));
        // Accumulation keeps the right-justified settings only
        for (int s = 0; s < 8; s++) run(1'b0, 1'b1, 8'(((s % 4) << 3) | s));
        run(1'b1, 1'b0, 8'h03, 1'b1);
        // Twelve-bit runs use a repeat setting of at least one
        for (int s = 1; s < 4; s++) run(1'b1, 1'b1, 8'(8'h80 | s));
        win_exp = 1'b0;
        wb(1'b1, ARW_OFF_CONTROL0, 8'h00);
        @(posedge clock_i);
        chk("cleared window flag", 16'h0, {15'h0, win_flag});
        complete_run();
    end
endmodule
